/* File: hw/wdog_pkg.sv */
// constants and types shared by the watchdog block
package wdog_pkg;
   // register byte addresses
   localparam logic [31:0] CONFIG_ADDR = 32'h5002_0018;
   localparam logic [31:0] SERVICE_ADDR = 32'h5002_001C;
   // configuration field layout
   localparam int RUN_BIT = 0;
   localparam int RESET_EN_BIT = 1;
   localparam int CAUSE_BIT = 2;
   localparam int SEL_LSB = 3;
   localparam int SEL_MSB = 4;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic CFG_BIT_RESET = 1'b0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   // service words
   localparam logic [31:0] SERVICE_FIRST = 32'h3C57_0001;
   localparam logic [31:0] SERVICE_SECOND = 32'h007F_4AD6;
   // timeout lengths in cycles, one per select code
   localparam logic [32:0] TIMEOUT_0 = 33'h0_0000_2000;
   localparam logic [32:0] TIMEOUT_1 = 33'h0_0008_0000;
   localparam logic [32:0] TIMEOUT_2 = 33'h0_0040_0000;
   localparam logic [32:0] TIMEOUT_3 = 33'h1_0000_0000;
   localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
   localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
   // edges after reset release before the synchronised cause is trusted
   localparam logic [1:0] SETTLE_ZERO = 2'h0;
   localparam logic [1:0] SETTLE_LAST = 2'h2;

   typedef enum logic {
      svc_idle,
      svc_armed
   } svc_state_t;
endpackage

/* File: hw/wdog_counter.sv */
// timeout counter: climbs while running, wraps and pulses expire at the terminal
`timescale 1ns/10ps
module wdog_counter (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   input wire logic restart,
   input wire logic [31:0] term_last,
   // status
   output logic [31:0] count,
   output logic expire
);
   typedef struct packed {
      logic [31:0] count;
      logic expire;
   } cnt_state_t;

   cnt_state_t s;
   cnt_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.expire = 1'b0;
      if (!run || restart) begin
         next_s.count = wdog_pkg::COUNT_ZERO;
      end else if (s.count >= term_last) begin
         // a shorter select chosen mid-count wraps at once instead of running to 2^32
         next_s.count = wdog_pkg::COUNT_ZERO;
         next_s.expire = 1'b1;
      end else begin
         next_s.count = s.count + wdog_pkg::COUNT_STEP;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign count = s.count;
   assign expire = s.expire;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_expire_cause: assert property (expire |-> $past(count) >= $past(term_last)
      && $past(run) && !$past(restart))
      else $error("expire without reaching the terminal count");
   a_stopped_zero: assert property (!run |=> count == wdog_pkg::COUNT_ZERO)
      else $error("counter moved while stopped");
   a_count_climbs: assert property (run && !restart && count < term_last
      |=> count == $past(count) + wdog_pkg::COUNT_STEP)
      else $error("counter did not advance by one");
   a_restart_zero: assert property (restart |=> count == wdog_pkg::COUNT_ZERO && !expire)
      else $error("restart did not clear the count");
endmodule

/* File: hw/sticky_watchdog.sv */
// watchdog with sticky enables, reset-cause flag and two-word service, on apb
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module sticky_watchdog #(
   // timeout lengths per select code, shortened in simulation
   parameter logic [32:0] timeout_0 = wdog_pkg::TIMEOUT_0,
   parameter logic [32:0] timeout_1 = wdog_pkg::TIMEOUT_1,
   parameter logic [32:0] timeout_2 = wdog_pkg::TIMEOUT_2,
   parameter logic [32:0] timeout_3 = wdog_pkg::TIMEOUT_3
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // reset controller side
   input wire logic prev_reset_by_wdog,
   output logic wdog_timeout,
   output logic wdog_reset_req,
   output logic wdog_running
);
   typedef struct packed {
      logic cause_meta;
      logic cause_sync;
      logic [1:0] settle;
      logic init_done;
      logic run;
      logic reset_en;
      logic cause;
      logic [1:0] sel;
      wdog_pkg::svc_state_t svc;
      logic service;
      logic [31:0] rdata;
      logic reset_req;
   } ctl_state_t;

   ctl_state_t s;
   ctl_state_t next_s;

   logic setup;
   logic access;
   logic hit_config;
   logic hit_service;
   logic wr_config;
   logic wr_service;
   logic [31:0] term_last;
   logic [31:0] count;
   logic expire;

   // last count value before wrap for a select code
   function automatic logic [31:0] last_count(input logic [1:0] sel);
      logic [32:0] len;
      len = timeout_0;
      unique case (sel)
         2'h0: len = timeout_0;
         2'h1: len = timeout_1;
         2'h2: len = timeout_2;
         2'h3: len = timeout_3;
      endcase
      return 32'(len - 33'h0_0000_0001);
   endfunction

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit_config = paddr == wdog_pkg::CONFIG_ADDR;
   assign hit_service = paddr == wdog_pkg::SERVICE_ADDR;
   assign wr_config = access && pwrite && hit_config;
   assign wr_service = access && pwrite && hit_service;
   assign term_last = last_count(s.sel);

   // zero wait states; only the two mapped words answer without error
   assign pready = 1'b1;
   assign pslverr = access && !(hit_config || hit_service);

   always_comb begin
      next_s = s;
      next_s.service = 1'b0;

      // cause level comes from the reset controller, another domain
      next_s.cause_meta = prev_reset_by_wdog;
      next_s.cause_sync = s.cause_meta;

      // the cause is caught once, after the synchroniser has settled
      if (!s.init_done) begin
         if (s.settle == wdog_pkg::SETTLE_LAST) begin
            next_s.init_done = 1'b1;
            next_s.cause = s.cause_sync;
         end else begin
            next_s.settle = 2'(s.settle + 2'h1);
         end
      end

      if (wr_config) begin
         // enables are set-only, a zero leaves them as they are
         next_s.run = s.run || pwdata[wdog_pkg::RUN_BIT];
         next_s.reset_en = s.reset_en || pwdata[wdog_pkg::RESET_EN_BIT];
         next_s.sel = pwdata[wdog_pkg::SEL_MSB:wdog_pkg::SEL_LSB];
         // a clear that comes before the cause is caught is dropped, so the load wins;
         // software must wait for the capture before it clears the flag
         if (s.init_done && !pwdata[wdog_pkg::CAUSE_BIT]) begin
            next_s.cause = 1'b0;
         end
      end

      // any completed access other than the expected word drops the sequence
      if (access) begin
         next_s.svc = wdog_pkg::svc_idle;
         if (wr_service) begin
            if (s.svc == wdog_pkg::svc_armed && pwdata == wdog_pkg::SERVICE_SECOND) begin
               next_s.service = 1'b1;
            end else if (pwdata == wdog_pkg::SERVICE_FIRST) begin
               next_s.svc = wdog_pkg::svc_armed;
            end
         end
      end

      // read data registered during setup so it is stable through access
      next_s.rdata = wdog_pkg::READ_ZERO;
      if (setup && !pwrite && hit_config) begin
         next_s.rdata[wdog_pkg::RUN_BIT] = s.run;
         next_s.rdata[wdog_pkg::RESET_EN_BIT] = s.reset_en;
         next_s.rdata[wdog_pkg::CAUSE_BIT] = s.cause;
         next_s.rdata[wdog_pkg::SEL_MSB:wdog_pkg::SEL_LSB] = s.sel;
      end

      // held until the system reset that it requests clears it
      if (expire && s.reset_en) begin
         next_s.reset_req = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.cause_meta <= 1'b0;
         s.cause_sync <= 1'b0;
         s.settle <= wdog_pkg::SETTLE_ZERO;
         s.init_done <= 1'b0;
         s.run <= wdog_pkg::CFG_BIT_RESET;
         s.reset_en <= wdog_pkg::CFG_BIT_RESET;
         s.cause <= wdog_pkg::CFG_BIT_RESET;
         s.sel <= wdog_pkg::SEL_RESET;
         s.svc <= wdog_pkg::svc_idle;
         s.service <= 1'b0;
         s.rdata <= wdog_pkg::READ_ZERO;
         s.reset_req <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // a service in the same cycle as the terminal count wins
   wdog_counter u_counter (
      .pclk(pclk),
      .presetn(presetn),
      .run(s.run),
      .restart(s.service),
      .term_last(term_last),
      .count(count),
      .expire(expire)
   );

   assign prdata = s.rdata;
   assign wdog_timeout = expire;
   assign wdog_reset_req = s.reset_req;
   assign wdog_running = s.run;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // enables are set-only: nothing but presetn brings them down
   a_run_sticky: assert property (s.run |=> s.run)
      else $error("run bit was cleared");

   a_run_set: assert property (wr_config && pwdata[wdog_pkg::RUN_BIT] |=> s.run)
      else $error("writing one did not start the watchdog");

   a_timeout_reset_enable_sticky: assert property (s.reset_en |=> s.reset_en)
      else $error("reset enable was cleared");

   a_timeout_reset_enable_set: assert property (wr_config && pwdata[wdog_pkg::RESET_EN_BIT]
      |=> s.reset_en)
      else $error("writing one did not arm the reset action");

   // a write to any other word leaves the configuration alone
   a_config_other: assert property (access && pwrite && !hit_config
      |=> $stable(s.run) && $stable(s.reset_en) && $stable(s.sel))
      else $error("configuration moved on a write elsewhere");

   // select is plain read-write and moves only on a config write
   a_select_write: assert property (wr_config
      |=> s.sel == $past(pwdata[wdog_pkg::SEL_MSB:wdog_pkg::SEL_LSB]))
      else $error("select not taken from the write");

   a_select_hold: assert property (!wr_config |=> $stable(s.sel))
      else $error("select moved without a write");

   a_select_len: assert property (s.run && !s.service && count == term_last
      |=> expire)
      else $error("terminal count of the selected length gave no timeout");

   // timeout is one cycle wide and leaves the count at zero
   a_timeout_pulse: assert property (wdog_timeout |=> !wdog_timeout)
      else $error("timeout pulse wider than one cycle");

   a_wrap_zero: assert property (wdog_timeout |-> count == wdog_pkg::COUNT_ZERO)
      else $error("count did not wrap with the timeout");

   a_expire_gap: assert property (wdog_timeout
      |=> count == wdog_pkg::COUNT_STEP || $past(s.service))
      else $error("count did not climb again after the timeout");

   // a stopped watchdog never times out, and its first count follows the run bit
   a_stopped_quiet: assert property (!s.run |-> !wdog_timeout)
      else $error("timeout while stopped");

   a_first_count: assert property ($rose(s.run) && !s.service
      |-> count == wdog_pkg::COUNT_ZERO ##1 count == wdog_pkg::COUNT_STEP)
      else $error("count did not start from zero after enable");

   // the reset request latches until presetn and needs the enable behind it
   a_reset_follows: assert property (expire && s.reset_en |=> wdog_reset_req)
      else $error("timeout with reset enabled gave no reset request");

   a_reset_needs_en: assert property ($rose(wdog_reset_req) |-> $past(s.reset_en)
      && $past(expire))
      else $error("reset request without enabled timeout");

   a_reset_held: assert property (wdog_reset_req |=> wdog_reset_req)
      else $error("reset request dropped before reset");

   a_reset_quiet: assert property (!s.reset_en |=> !wdog_reset_req)
      else $error("reset request with the reset action off");

   // the first word arms, and only the second word right after it services
   a_service_arm: assert property (wr_service && pwdata == wdog_pkg::SERVICE_FIRST
      |=> s.svc == wdog_pkg::svc_armed)
      else $error("first service word did not arm");

   a_service_pair: assert property (s.service |-> $past(wr_service)
      && $past(pwdata) == wdog_pkg::SERVICE_SECOND
      && $past(s.svc) == wdog_pkg::svc_armed)
      else $error("service accepted without the ordered pair");

   a_second_alone: assert property (wr_service && pwdata == wdog_pkg::SERVICE_SECOND
      && s.svc == wdog_pkg::svc_idle |=> !s.service)
      else $error("second word alone serviced the watchdog");

   a_service_single: assert property (s.service |=> !s.service)
      else $error("one pair serviced twice");

   a_service_restart: assert property (s.service |=> count == wdog_pkg::COUNT_ZERO
      ##1 !expire)
      else $error("service did not restart the count");

   a_restart_quiet: assert property (s.service |=> !wdog_timeout)
      else $error("timeout right after a service");

   // any other transfer between the two words throws the first one away
   a_discard_other: assert property (access && !(wr_service
      && pwdata == wdog_pkg::SERVICE_FIRST) |=> s.svc == wdog_pkg::svc_idle)
      else $error("partial service survived another access");

   a_other_no_service: assert property (s.svc == wdog_pkg::svc_armed && access
      && !wr_service |=> !s.service)
      else $error("service completed by another access");

   a_cfg_discard: assert property (wr_config |=> s.svc == wdog_pkg::svc_idle)
      else $error("config write kept a partial service");

   // the cause is caught exactly once, three edges after release
   a_cause_settle: assert property (s.settle == wdog_pkg::SETTLE_ZERO && !s.init_done
      |-> ##3 s.init_done)
      else $error("cause flag not caught three edges after reset");

   a_settle_step: assert property (!s.init_done && s.settle != wdog_pkg::SETTLE_LAST
      |=> s.settle == 2'($past(s.settle) + 2'h1))
      else $error("settle counter skipped a step");

   a_cause_load: assert property (!s.init_done && s.settle == wdog_pkg::SETTLE_LAST
      |=> s.cause == $past(s.cause_sync) && s.init_done)
      else $error("cause flag not loaded from the reset controller");

   a_init_once: assert property (s.init_done |=> s.init_done && $stable(s.settle))
      else $error("cause capture ran a second time");

   a_cause_clear: assert property ($fell(s.cause) |-> $past(wr_config)
      && !$past(pwdata[wdog_pkg::CAUSE_BIT]))
      else $error("cause flag fell without a clearing write");

   a_cause_hold: assert property (s.init_done && !s.cause |=> !s.cause)
      else $error("cause flag set after initialization");

   a_cause_cleared: assert property (s.init_done && wr_config
      && !pwdata[wdog_pkg::CAUSE_BIT] |=> !s.cause)
      else $error("clearing write left the cause flag set");

   a_cause_keep: assert property (s.init_done && wr_config
      && pwdata[wdog_pkg::CAUSE_BIT] |=> $stable(s.cause))
      else $error("writing one changed the cause flag");

   // reset state and the read path of the configuration word
   a_config_reset: assert property (s.settle == wdog_pkg::SETTLE_ZERO && !s.init_done
      |-> !s.run && !s.reset_en && s.sel == wdog_pkg::SEL_RESET && !s.cause)
      else $error("configuration not zero after reset");

   a_read_config: assert property (setup && !pwrite && hit_config
      |=> prdata[wdog_pkg::SEL_MSB:wdog_pkg::SEL_LSB] == $past(s.sel)
      && prdata[wdog_pkg::RUN_BIT] == $past(s.run))
      else $error("config read returned the wrong fields");

   a_read_flags: assert property (setup && !pwrite && hit_config
      |=> prdata[wdog_pkg::CAUSE_BIT] == $past(s.cause)
      && prdata[wdog_pkg::RESET_EN_BIT] == $past(s.reset_en))
      else $error("config read returned the wrong flags");

   a_read_idle: assert property (!(setup && !pwrite && hit_config)
      |=> prdata == wdog_pkg::READ_ZERO)
      else $error("read data not zero outside a config read");

   a_rdata_write: assert property (setup && pwrite |=> prdata == wdog_pkg::READ_ZERO)
      else $error("read data driven during a write");

   a_slverr_map: assert property (access
      |-> pslverr == !(hit_config || hit_service))
      else $error("error response on the wrong address");

   a_slverr_idle: assert property (!access |-> !pslverr)
      else $error("error response outside an access phase");

   // main scenarios that the bench is expected to reach
   c_service_done: cover property (s.svc == wdog_pkg::svc_armed ##1 s.service);
   c_timeout: cover property (s.run ##[1:1000] expire);
   c_reset_req: cover property ($rose(wdog_reset_req));
   c_cause_set: cover property ($rose(s.cause));
   c_discard: cover property (s.svc == wdog_pkg::svc_armed && access && !wr_service);
endmodule

/* File: verif/test_sticky_watchdog.sv */
// self-checking bench for the sticky watchdog over apb
`timescale 1ns/10ps
module test_sticky_watchdog;
   localparam logic [32:0] TMO [4] = '{33'h0_0000_0010, 33'h0_0000_0020,
      33'h0_0000_0040, 33'h0_0000_0080};
   localparam logic [31:0] CA = wdog_pkg::CONFIG_ADDR;
   localparam logic [31:0] SA = wdog_pkg::SERVICE_ADDR;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic prev_reset_by_wdog = 1'b0;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic wdog_timeout;
   logic wdog_reset_req;
   logic wdog_running;
   int n_mismatch = 0;
   int checks = 0;
   logic [7:0] lf = 8'h60;

   sticky_watchdog #(.timeout_0(TMO[0]), .timeout_1(TMO[1]), .timeout_2(TMO[2]),
      .timeout_3(TMO[3])) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .prev_reset_by_wdog(prev_reset_by_wdog), .wdog_timeout(wdog_timeout),
      .wdog_reset_req(wdog_reset_req), .wdog_running(wdog_running));

   initial begin
      forever #25 pclk = ~pclk;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task results;
      if (n_mismatch == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task chk(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // request stands until the rising edge at which pready is seen high; data taken there
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            rd = prdata;
            err = pslverr;
            break;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         n_mismatch++;
         results();
      end
   endtask

   task wait_tmo(output int n);
      for (n = 0; n < 300; n++) begin
         @(negedge pclk);
         if (wdog_timeout === 1'b1) break;
      end
      if (n == 300) begin
         n_mismatch++;
         results();
      end
   endtask

   task do_reset(input logic cause);
      presetn <= 1'b0;
      prev_reset_by_wdog <= cause;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // cause flag is loaded three edges after release
      repeat (4) @(posedge pclk);
   endtask

   initial begin
      logic [31:0] rd;
      logic err;
      int n;
      int nref;
      logic [31:0] aa [15];
      logic ww [15];
      logic [31:0] dd [15];
      for (int s = 0; s < 4; s++) begin
         lf = lfsr_next(lf);
         do_reset(lf[0]);
         apb(1'b0, CA, 32'h0000_0000, rd, err);
         chk(rd, {29'h0, lf[0], 2'b00});
         chk(err, 1'b0);
         chk(wdog_running, 1'b0);
         apb(1'b1, CA, {27'h0, s[1:0], 3'b001}, rd, err);
         wait_tmo(n);
         chk(n, TMO[s]);
         chk(wdog_running, 1'b1);
         apb(1'b0, CA, 32'h0000_0000, rd, err);
         chk(rd, {27'h0, s[1:0], 3'b001});
      end
      // each case is three transfers; only case 1 is a clean service pair
      aa = '{CA, CA, CA, CA, SA, SA, SA, SA, SA, SA, SA, SA, CA, CA, SA};
      ww = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 0, 1, 0, 0, 1};
      dd = '{0, 0, 0, 0, wdog_pkg::SERVICE_FIRST, wdog_pkg::SERVICE_SECOND,
         wdog_pkg::SERVICE_FIRST, {24'h0, lf}, wdog_pkg::SERVICE_SECOND,
         wdog_pkg::SERVICE_FIRST, 0, wdog_pkg::SERVICE_SECOND, 0, 0,
         wdog_pkg::SERVICE_SECOND};
      for (int c = 0; c < 5; c++) begin
         wait_tmo(n);
         for (int t = 0; t < 3; t++) begin
            apb(ww[c*3+t], aa[c*3+t], dd[c*3+t], rd, err);
         end
         wait_tmo(n);
         if (c == 0) begin
            nref = n;
         end else begin
            chk(n, (c == 1) ? TMO[3] + 1 : nref);
         end
      end
      apb(1'b1, CA, 32'h0000_001B, rd, err);
      apb(1'b1, CA, 32'h0000_0018, rd, err);
      apb(1'b0, CA, 32'h0000_0000, rd, err);
      chk(rd, 32'h0000_001B);
      apb(1'b0, SA, 32'h0000_0000, rd, err);
      chk({err, rd}, 33'h0_0000_0000);
      apb(1'b0, 32'h5002_0020, 32'h0000_0000, rd, err);
      chk({err, rd}, 33'h1_0000_0000);
      wait_tmo(n);
      chk(wdog_reset_req, 1'b0);
      @(negedge pclk);
      chk(wdog_reset_req, 1'b1);
      results();
   end
endmodule
